// File: design/pin_change_consts.svh
/*
  Offsets, field positions, masks and reset values of the pin change
  interrupt block. Assumes an 8-bit register port with a 3-bit address.
*/
`ifndef PIN_CHANGE_CONSTS_SVH
`define PIN_CHANGE_CONSTS_SVH

// Register offsets on the plain register port.
`define OFS_IRQ_ENABLE    3'h0
`define OFS_IRQ_REQUEST   3'h1
`define OFS_A_RISE        3'h2
`define OFS_A_FALL        3'h3
`define OFS_A_FLAGS       3'h4
`define OFS_B_RISE        3'h5
`define OFS_B_FALL        3'h6
`define OFS_B_FLAGS       3'h7

// Field positions in the two peripheral interrupt registers.
`define MASTER_EN_BIT     4
`define SUMMARY_FLAG_BIT  4

// Implemented bits per port and the pins lost to the debugger.
`define PORT_A_MASK       8'hFF
`define PORT_B_MASK       8'hF0
`define DEBUG_PIN_MASK    8'h03

// Reset value of every register.
`define REG_RESET         8'h00

`endif

// File: design/pin_change_pkg.sv
/*
  Types shared by the pin change interrupt block.
  Assumes the constants header is compiled alongside.
*/
package pin_change_pkg;

   // One register port request, sampled on a rising clock edge.
   typedef struct packed
   {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } reg_req_t;

   // Enable and flag state of one port.
   typedef struct packed
   {
      logic [7:0] rise;
      logic [7:0] fall;
      logic [7:0] flags;
   } port_state_t;

endpackage

// File: design/pin_edge_change_interrupt.sv
/*
  Per-pin rising and falling edge detection for two input ports, with
  sticky per-pin flags, a summary flag, a master enable, an interrupt
  request and a wake-up request.
  Assumes pin inputs are already synchronous to clock, a register port
  whose read data appear one cycle after the read strobe, and
  strobes that are never high together.
*/
`include "pin_change_consts.svh"

// Summary of operation
// - Interrupt only while master enable is set
// - Flags still set while master enable clear
// - Each pin has rise and fall detectors
// - Rise detection armed by rise-enable bit
// - Fall detection armed by fall-enable bit
// - Both enables detect both polarities
// - No enables means no flag setting
// - Enabled edge sets that pin's flag
// - Summary flag is OR of all flags
// - Writing zero clears a flag
// - Edge during write keeps flag set
// - Change event wakes from Sleep if enabled
// - Port A registers eight bits, reset zero
// - Flags hardware set, software read/write, reset zero
// - Debugger takes port A bits 1 and 0
// - Port B rise enable bits 7-4 only
// - Port B fall and flags bits 7-4 only
module pin_edge_change_interrupt
(
   // Clock and reset.
   input  wire logic                      clock,
   input  wire logic                      rst_n,
   // Register port.
   input  wire pin_change_pkg::reg_req_t  reg_req,
   output logic      [7:0]                reg_rdata,
   // Port pins and debugger state.
   input  wire logic [7:0]                port_a_pin,
   input  wire logic [7:0]                port_b_pin,
   input  wire logic                      debug_enable,
   // Requests to the interrupt and power logic.
   output logic                           irq_out,
   output logic                           change_irq_summary_flag,
   output logic                           wake_req
);

   ////////////////////////////////////////////////////////////////////
   // Edge decision for one port: a pin is hit when its new sample
   // differs from the previous one in an armed direction.
   function automatic logic [7:0] edge_hit
   (
      input logic [7:0] cur,
      input logic [7:0] prev,
      input logic [7:0] rise,
      input logic [7:0] fall,
      input logic [7:0] mask
   );
      edge_hit = ((cur & ~prev & rise) | (~cur & prev & fall)) & mask;
   endfunction

   // Next flag value: a write replaces the stored flags, but any
   // edge seen in the same cycle is ORed in afterwards and wins.
   function automatic logic [7:0] flag_next
   (
      input logic [7:0] cur,
      input logic       wr,
      input logic [7:0] wdata,
      input logic [7:0] set,
      input logic [7:0] mask
   );
      flag_next = ((wr ? wdata : cur) | set) & mask;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // State.
   pin_change_pkg::port_state_t a_r;
   pin_change_pkg::port_state_t b_r;
   logic                        master_en_r;
   logic [7:0]                  prev_a_r;
   logic [7:0]                  prev_b_r;
   logic                        primed_r;
   logic [7:0]                  rdata_r;
   logic                        summary_r;
   logic                        irq_r;
   logic                        wake_r;

   ////////////////////////////////////////////////////////////////////
   // Address decode of the register port.
   wire wr_en     = reg_req.wr && reg_req.addr == `OFS_IRQ_ENABLE;
   wire wr_a_rise = reg_req.wr && reg_req.addr == `OFS_A_RISE;
   wire wr_a_fall = reg_req.wr && reg_req.addr == `OFS_A_FALL;
   wire wr_a_flag = reg_req.wr && reg_req.addr == `OFS_A_FLAGS;
   wire wr_b_rise = reg_req.wr && reg_req.addr == `OFS_B_RISE;
   wire wr_b_fall = reg_req.wr && reg_req.addr == `OFS_B_FALL;
   wire wr_b_flag = reg_req.wr && reg_req.addr == `OFS_B_FLAGS;

   // While debug_enable is set the debugger owns two port A pins, so they do not detect.
   // Their enable and flag bits stay readable and writable meanwhile.
   wire [7:0] a_mask = debug_enable ? (`PORT_A_MASK & ~`DEBUG_PIN_MASK)
                                    : `PORT_A_MASK;

   // Detection is held off for the first cycle after reset, because
   // the previous sample is not yet a real pin value then.
   wire [7:0] set_a = primed_r ? edge_hit(port_a_pin, prev_a_r,
                                          a_r.rise, a_r.fall, a_mask)
                               : 8'h00;
   wire [7:0] set_b = primed_r ? edge_hit(port_b_pin, prev_b_r,
                                          b_r.rise, b_r.fall,
                                          `PORT_B_MASK)
                               : 8'h00;

   // Next values of the stored registers.
   wire       en_nxt     = wr_en ? reg_req.wdata[`MASTER_EN_BIT]
                                 : master_en_r;
   wire [7:0] a_rise_nxt = wr_a_rise ? reg_req.wdata : a_r.rise;
   wire [7:0] a_fall_nxt = wr_a_fall ? reg_req.wdata : a_r.fall;
   wire [7:0] b_rise_nxt = wr_b_rise ? reg_req.wdata & `PORT_B_MASK
                                     : b_r.rise;
   wire [7:0] b_fall_nxt = wr_b_fall ? reg_req.wdata & `PORT_B_MASK
                                     : b_r.fall;
   wire [7:0] a_flag_nxt = flag_next(a_r.flags, wr_a_flag,
                                     reg_req.wdata, set_a,
                                     `PORT_A_MASK);
   wire [7:0] b_flag_nxt = flag_next(b_r.flags, wr_b_flag,
                                     reg_req.wdata, set_b,
                                     `PORT_B_MASK);

   // The summary follows the flags whatever the master enable says.
   wire summary_nxt = |{a_flag_nxt, b_flag_nxt};
   wire irq_nxt     = summary_nxt && en_nxt;
   // Wake-up uses the stored enable, so an enable written in the cycle
   // of an edge raises the request but not the wake-up for that edge.
   wire wake_nxt    = |{set_a, set_b} && master_en_r;

   // Read multiplexer; unmapped bits read as zero.
   wire [7:0] en_view  = 8'h00 | ({7'h00, master_en_r}
                                  << `MASTER_EN_BIT);
   wire [7:0] req_view = 8'h00 | ({7'h00, summary_r}
                                  << `SUMMARY_FLAG_BIT);
   logic [7:0] rd_mux;
   always_comb
   begin
      case (reg_req.addr)
         `OFS_IRQ_ENABLE:  rd_mux = en_view;
         `OFS_IRQ_REQUEST: rd_mux = req_view;
         `OFS_A_RISE:      rd_mux = a_r.rise;
         `OFS_A_FALL:      rd_mux = a_r.fall;
         `OFS_A_FLAGS:     rd_mux = a_r.flags;
         `OFS_B_RISE:      rd_mux = b_r.rise;
         `OFS_B_FALL:      rd_mux = b_r.fall;
         `OFS_B_FLAGS:     rd_mux = b_r.flags;
         default:          rd_mux = 8'h00;
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // Enable and flag registers; every one clears at reset.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         a_r         <= {3{`REG_RESET}};
         b_r         <= {3{`REG_RESET}};
         master_en_r <= 1'b0;
      end
      else
      begin
         a_r         <= {a_rise_nxt, a_fall_nxt, a_flag_nxt};
         b_r         <= {b_rise_nxt, b_fall_nxt, b_flag_nxt};
         master_en_r <= en_nxt;
      end
   end

   // Previous pin samples for edge detection.
   // A pin already high when reset lifts is not taken as a rising edge.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prev_a_r <= 8'h00;
         prev_b_r <= 8'h00;
         primed_r <= 1'b0;
      end
      else
      begin
         prev_a_r <= port_a_pin;
         prev_b_r <= port_b_pin;
         primed_r <= 1'b1;
      end
   end

   // Registered outputs, aligned with the stored flags.
   // Idle read data are zero, so several slaves may share an OR bus.
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rdata_r   <= 8'h00;
         summary_r <= 1'b0;
         irq_r     <= 1'b0;
         wake_r    <= 1'b0;
      end
      else
      begin
         rdata_r   <= reg_req.rd ? rd_mux : 8'h00;
         summary_r <= summary_nxt;
         irq_r     <= irq_nxt;
         wake_r    <= wake_nxt;
      end
   end

   assign reg_rdata               = rdata_r;
   assign change_irq_summary_flag = summary_r;
   assign irq_out                 = irq_r;
   assign wake_req                = wake_r;

   ////////////////////////////////////////////////////////////////////
   // Checks on the block's own behaviour.
   // They watch the internal edge wires as well as the outputs, so a
   // wrong decision shows in the cycle it is made, not a cycle later.
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   flag_set_a: assert property (
      (|set_a) |=> ((a_r.flags & $past(set_a)) == $past(set_a)))
      else $error("Enabled edge did not set its flag.");

   set_wins_a: assert property (
      (wr_b_flag && |set_b)
      |=> ((b_r.flags & $past(set_b)) == $past(set_b)))
      else $error("Flag write lost a same-cycle edge.");

   wr_clear_a: assert property (
      (wr_a_flag && set_a == 8'h00)
      |=> a_r.flags == $past(reg_req.wdata))
      else $error("Flag write did not store written value.");

   no_enable_a: assert property (
      (!wr_a_flag && (a_r.rise | a_r.fall) == 8'h00)
      |=> $stable(a_r.flags))
      else $error("Flag changed with no edge enabled.");

   dbg_pins_a: assert property (
      (debug_enable && !wr_a_flag && a_r.flags[1:0] == 2'b00)
      |=> a_r.flags[1:0] == 2'b00)
      else $error("Debugger pins set a change flag.");

   both_edge_a: assert property (
      primed_r |-> ((port_a_pin ^ prev_a_r) & a_r.rise & a_r.fall
                    & a_mask & ~set_a) == 8'h00)
      else $error("Pin change missed with both enables set.");

   static_pin_a: assert property (
      (primed_r && port_a_pin == prev_a_r) |-> set_a == 8'h00)
      else $error("Edge reported on a static pin.");

   summary_or_a: assert property (
      summary_r == |{a_r.flags, b_r.flags})
      else $error("Summary flag differs from OR of flags.");

   irq_gate_a: assert property (
      irq_r == (summary_r && master_en_r))
      else $error("Request not summary AND master enable.");

   flags_off_a: assert property (
      (!en_nxt && |{set_a, set_b}) |=> (summary_r && !irq_r))
      else $error("Flag not kept or request raised while off.");

   wake_a: assert property (
      (master_en_r && |{set_a, set_b}) |=> wake_r)
      else $error("Enabled change did not raise wake-up.");

   b_low_a: assert property (
      ((b_r.rise | b_r.fall | b_r.flags) & ~`PORT_B_MASK) == 8'h00)
      else $error("Unimplemented port B bit is set.");

   read_rise_a: assert property (
      (reg_req.rd && reg_req.addr == `OFS_A_RISE)
      |=> reg_rdata == $past(a_r.rise))
      else $error("Read data wrong one cycle after strobe.");

   ////////////////////////////////////////////////////////////////////
   // Arming, races, stickiness and the register port.
   b_flag_set_a: assert property (
      (|set_b) |=> ((b_r.flags & $past(set_b)) == $past(set_b)))
      else $error("Enabled port B edge did not set its flag.");

   rise_only_a: assert property (
      (set_a & port_a_pin & ~prev_a_r & ~a_r.rise) == 8'h00)
      else $error("Rising edge flagged with rise detection off.");

   fall_only_a: assert property (
      (set_a & ~port_a_pin & prev_a_r & ~a_r.fall) == 8'h00)
      else $error("Falling edge flagged with fall detection off.");

   race_keep_a: assert property (
      (wr_a_flag && |set_a)
      |=> ((a_r.flags & $past(set_a)) == $past(set_a)))
      else $error("Port A flag write lost a same-cycle edge.");

   b_wr_clear_a: assert property (
      (wr_b_flag && set_b == 8'h00)
      |=> b_r.flags == ($past(reg_req.wdata) & `PORT_B_MASK))
      else $error("Port B flag write did not store written value.");

   flag_hold_a: assert property (
      !wr_a_flag
      |=> ((a_r.flags & $past(a_r.flags)) == $past(a_r.flags)))
      else $error("Port A flag dropped without a write.");

   irq_hold_a: assert property (
      (irq_r && !wr_a_flag && !wr_b_flag && !wr_en)
      |=> irq_r)
      else $error("Request dropped while flags were left set.");

   wake_off_a: assert property (
      !(master_en_r && |{set_a, set_b}) |=> !wake_r)
      else $error("Wake-up raised with no enabled change.");

   en_store_a: assert property (
      wr_en
      |=> master_en_r == $past(reg_req.wdata[`MASTER_EN_BIT]))
      else $error("Master enable write not stored.");

   rd_req_a: assert property (
      (reg_req.rd && reg_req.addr == `OFS_IRQ_REQUEST)
      |=> reg_rdata[`SUMMARY_FLAG_BIT] == $past(summary_r))
      else $error("Request register read wrong summary flag.");

   rdata_idle_a: assert property (
      !reg_req.rd |=> reg_rdata == 8'h00)
      else $error("Read data not zero outside a read.");

   // Main scenarios.
   cov_irq: cover property (master_en_r && |set_a ##1 irq_r);
   cov_race: cover property (wr_a_flag && |set_a);
   cov_quiet: cover property (!master_en_r && |{set_a, set_b} ##1 summary_r);
   cov_clear: cover property (irq_r ##[1:20] !irq_r);
   cov_both: cover property (|(set_a & a_r.rise & a_r.fall));

endmodule

// File: sim/pin_source.sv
/*
  Behavioural source of the two port pin buses seen by the change block.
  Assumes the bench calls drive once per change and that pins are
  already synchronous to clock, so levels move only after a rising edge.
*/
module pin_source
(
   // Clock.
   input  wire logic       clock,
   // Pin levels seen by the block.
   output logic      [7:0] port_a_pin,
   output logic      [7:0] port_b_pin
);
   timeunit 1ns;
   timeprecision 1ps;

   ////////////////////////////////////////////////////////////////////////
   // Pins start low so the first sample after reset holds no edge.
   initial
   begin
      port_a_pin = 8'h00;
      port_b_pin = 8'h00;
   end

   // New levels land just after an edge, never on the sampling instant.
   task automatic drive(input logic [7:0] a, input logic [7:0] b);
      @(posedge clock);
      port_a_pin <= a;
      port_b_pin <= b;
   endtask
endmodule

// File: sim/tb.sv
/*
  Self-checking bench for the pin change interrupt block.
  Assumes the constants header and package are compiled first.
*/
`include "pin_change_consts.svh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic                     clock;
   logic                     rst_n;
   pin_change_pkg::reg_req_t reg_req;
   logic [7:0]               reg_rdata;
   logic [7:0]               port_a_pin;
   logic [7:0]               port_b_pin;
   logic                     debug_enable;
   logic                     irq_out;
   logic                     summary;
   logic                     wake_req;
   int                       n_errors;
   int                       checks_done;

   pin_edge_change_interrupt u_pin_edge_change_interrupt
   (
      .clock                   (clock),
      .rst_n                   (rst_n),
      .reg_req                 (reg_req),
      .reg_rdata               (reg_rdata),
      .port_a_pin              (port_a_pin),
      .port_b_pin              (port_b_pin),
      .debug_enable            (debug_enable),
      .irq_out                 (irq_out),
      .change_irq_summary_flag (summary),
      .wake_req                (wake_req)
   );

   pin_source u_pin_source
   (
      .clock      (clock),
      .port_a_pin (port_a_pin),
      .port_b_pin (port_b_pin)
   );

   ////////////////////////////////////////////////////////////////////////
   // A half period of 2.5 ns gives the 200 MHz clock.
   always #2.5 clock = ~clock;

   task automatic end_of_test;
      if (n_errors == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp,
                      input logic [7:0] got);
      checks_done++;
      if (got !== exp)
      begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Strobes are dropped a full edge later, so calls never collide.
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_req.addr  <= a;
      reg_req.wdata <= d;
      reg_req.wr    <= 1'b1;
      @(posedge clock);
      reg_req.wr    <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe.
   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clock);
      reg_req.addr <= a;
      reg_req.rd   <= 1'b1;
      @(posedge clock);
      reg_req.rd   <= 1'b0;
      #1 chk("read data", exp, reg_rdata);
      @(posedge clock);
      #1 chk("read idle", 8'h00, reg_rdata);
   endtask

   // The wake pulse must show one cycle after the pin moves, then go.
   task automatic pin(input logic [7:0] a, input logic [7:0] b,
                      input logic w);
      u_pin_source.drive(a, b);
      @(posedge clock);
      #1 chk("wake", {7'h00, w}, {7'h00, wake_req});
      @(posedge clock);
      #1 chk("wake end", 8'h00, {7'h00, wake_req});
   endtask

   task automatic st(input logic [1:0] e);
      @(posedge clock);
      #1 chk("summary irq", {6'h00, e}, {6'h00, summary, irq_out});
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Watchdog: the tests need a few hundred cycles at most.
   initial
   begin
      repeat (3000) @(posedge clock);
      n_errors++;
      end_of_test();
   end

   // Main sequence: reset, register access, then edge behaviour.
   initial
   begin
      clock = 1'b0;
      rst_n = 1'b0;
      reg_req = '0;
      debug_enable = 1'b0;
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      for (int i = 0; i < 8; i++)
         rd(3'(i), `REG_RESET);
      wr(`OFS_A_FALL, 8'hFF);
      rd(`OFS_A_FALL, 8'hFF);
      wr(`OFS_B_RISE, 8'hFF);
      rd(`OFS_B_RISE, 8'hF0);
      wr(`OFS_B_FALL, 8'hFF);
      rd(`OFS_B_FALL, 8'hF0);
      wr(`OFS_B_FLAGS, 8'hFF);
      rd(`OFS_B_FLAGS, 8'hF0);
      rd(`OFS_IRQ_REQUEST, 8'h10);
      wr(`OFS_B_FLAGS, 8'h00);
      // Master enable off: flags still set but no request is raised.
      wr(`OFS_A_RISE, 8'h09);
      wr(`OFS_A_FALL, 8'h0A);
      pin(8'h01, 8'h00, 1'b0);
      st(2'b10);
      pin(8'h07, 8'h00, 1'b0);
      rd(`OFS_A_FLAGS, 8'h01);
      pin(8'h01, 8'h00, 1'b0);
      rd(`OFS_A_FLAGS, 8'h03);
      wr(`OFS_IRQ_ENABLE, 8'h10);
      st(2'b11);
      pin(8'h09, 8'h00, 1'b1);
      pin(8'h01, 8'h00, 1'b1);
      rd(`OFS_A_FLAGS, 8'h0B);
      // A clear written as an edge arrives leaves that flag set.
      fork
         u_pin_source.drive(8'h09, 8'h00);
         wr(`OFS_A_FLAGS, 8'h00);
      join
      rd(`OFS_A_FLAGS, 8'h08);
      wr(`OFS_A_FLAGS, 8'h08 & ~8'h08);
      rd(`OFS_A_FLAGS, 8'h00);
      st(2'b00);
      // The debugger pins must ignore edges while it is on.
      @(posedge clock);
      debug_enable <= 1'b1;
      wr(`OFS_A_RISE, 8'h03);
      pin(8'h0A, 8'h00, 1'b0);
      pin(8'h08, 8'h00, 1'b0);
      rd(`OFS_A_FLAGS, 8'h00);
      @(posedge clock);
      debug_enable <= 1'b0;
      pin(8'h0B, 8'h00, 1'b1);
      rd(`OFS_A_FLAGS, 8'h03);
      pin(8'h0B, 8'hFF, 1'b1);
      pin(8'h0B, 8'h00, 1'b1);
      rd(`OFS_B_FLAGS, 8'hF0);
      // A port B clear written as a port B edge arrives keeps that flag.
      fork
         u_pin_source.drive(8'h0B, 8'h30);
         wr(`OFS_B_FLAGS, 8'h00);
      join
      rd(`OFS_B_FLAGS, 8'h30);
      // A second reset in mid-run must clear every register again.
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      for (int i = 0; i < 8; i++)
         rd(3'(i), `REG_RESET);
      st(2'b00);
      end_of_test();
   end
endmodule
